// [htp_duty_meter.sv]
// Purpose: Far-side capture logic that reads back one duty-cycle pin
// Assumes: Pin is sampled on the system clock; duty strictly between 0 and 1
// Notes: Full-on or full-off gives no edge, so nothing is reported
`timescale 1ns/1ps
module htp_duty_meter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pwm,
  output logic [htp_pkg::DUTY_W-1:0] o_high,
  output logic o_valid
);
  logic [htp_pkg::DUTY_W-1:0] run_r;
  logic prev_r;
  // High time of each pulse, reported on its falling edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_r <= '0;
      prev_r <= 1'b0;
      o_valid <= 1'b0;
      o_high <= '0;
    end else begin
      run_r <= i_pwm ? (prev_r ? run_r + 1'b1 : 11'h001) : run_r;
      o_valid <= prev_r & ~i_pwm;
      o_high <= run_r;
      prev_r <= i_pwm;
    end
  end
endmodule

// [htp_pkg.sv]
// Purpose: Shared constants and state types for the humidity/temperature duty outputs
// Assumes: 40 MHz system clock; measurement values arrive in hundredths of a unit
// Notes: Duty is held as a count of high cycles out of one output period
package htp_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int MEAS_PERIOD_MS = 1000;
  localparam int MEAS_CYCLES = MEAS_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SEC_W = 26;
  localparam int VAL_W = 16;
  localparam int PWM_PERIOD = 1000;
  localparam int CNT_W = 10;
  localparam int DUTY_W = 11;
  // Value = span * duty - offset, all in hundredths
  localparam int HUM_OFS_CENTI = 600;
  localparam int HUM_SPAN_CENTI = 12500;
  localparam int TEMP_OFS_CENTI = 4685;
  localparam int TEMP_SPAN_CENTI = 17572;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [DUTY_W-1:0] active;
    logic [DUTY_W-1:0] pend;
    logic pend_v;
    logic pwm;
  } htp_chan_s;

  typedef struct packed {
    logic [SEC_W-1:0] sec_cnt;
    logic tick;
    logic load;
    logic [DUTY_W-1:0] hum_duty;
    logic [DUTY_W-1:0] temp_duty;
    logic first;
    logic second;
  } htp_top_s;
endpackage

// [htp_pwm_chan.sv]
// Purpose: One duty-cycle output channel with period-aligned update
// Assumes: i_load is a one-cycle pulse carrying a duty in 0..PWM_PERIOD
// Notes: A duty loaded mid-period waits for the next period start
`timescale 1ns/1ps
module htp_pwm_chan (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [htp_pkg::DUTY_W-1:0] i_duty,
  output logic o_pwm
);
  localparam logic [htp_pkg::CNT_W-1:0] LAST = htp_pkg::CNT_W'(htp_pkg::PWM_PERIOD - 1);
  htp_pkg::htp_chan_s st_r;
  htp_pkg::htp_chan_s st_nxt;
  logic wrap;

  assign wrap = (st_r.cnt == LAST);

  always_comb begin
    st_nxt = st_r;
    if (i_load) begin
      st_nxt.pend = i_duty;
      st_nxt.pend_v = 1'b1;
    end
    st_nxt.cnt = wrap ? '0 : st_r.cnt + 1'b1;
    // Swap duty only at the period boundary
    if (wrap && (st_r.pend_v || i_load)) begin
      st_nxt.active = i_load ? i_duty : st_r.pend;
      st_nxt.pend_v = 1'b0;
    end
    // High while count is under duty: fraction = high time / period
    st_nxt.pwm = ({1'b0, st_nxt.cnt} < st_nxt.active);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pwm = st_r.pwm;

  // Helper: high cycles seen so far in the current period
  logic [htp_pkg::DUTY_W-1:0] hi_cnt_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_r <= '0;
    end else begin
      hi_cnt_r <= wrap ? '0 : hi_cnt_r + htp_pkg::DUTY_W'(st_r.pwm);
    end
  end

  AST_HIGH_TIME: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wrap |-> (hi_cnt_r + htp_pkg::DUTY_W'(st_r.pwm) == st_r.active))
    else $error("High time in period differs from duty");
  AST_BOUNDARY_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.cnt != '0) |-> $stable(st_r.active))
    else $error("Duty changed inside a period");
  COV_PEND_APPLIED: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.pend_v ##1 !st_r.pend_v);
endmodule

// [htp_pwm_out.sv]
// Purpose: Once-per-second humidity and temperature duty-cycle outputs on two pins
// Assumes: Converter values are valid in the cycle before O_SAMPLE_TICK goes high; swap input is static
// Notes: Duty saturates only at 0 and 1; humidity outside 0..100 percent passes through
// What this block does
// - Every second take fresh humidity and temperature results and update both outputs.
// - Swap high: first pin humidity, second temperature; low: the reverse.
// - Humidity percent equals minus 6 plus 125 times duty fraction.
// - Temperature Celsius equals minus 46.85 plus 175.72 times duty fraction.
// - Duty fraction is high time over period, from zero to one.
// - Humidity is not clamped to 0..100 percent; slight overshoot is expected.
`timescale 1ns/1ps
module htp_pwm_out #(
  parameter int SEC_CYCLES = htp_pkg::MEAS_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic i_CHANNEL_SWAP,
  input wire logic signed [htp_pkg::VAL_W-1:0] i_HUM_CENTI,
  input wire logic signed [htp_pkg::VAL_W-1:0] i_TEMP_CENTI,
  output logic o_SAMPLE_TICK,
  output logic o_FIRST_DUTY,
  output logic o_SECOND_DUTY
);
  localparam logic [htp_pkg::SEC_W-1:0] SEC_LAST = htp_pkg::SEC_W'(SEC_CYCLES - 1);
  htp_pkg::htp_top_s st_r;
  htp_pkg::htp_top_s st_nxt;
  logic hum_pwm;
  logic temp_pwm;

  // Saturate only at duty 0 and 1, which the waveform cannot exceed
  function automatic logic [htp_pkg::DUTY_W-1:0] to_duty(
    input logic signed [htp_pkg::VAL_W-1:0] v, input int ofs, input int span);
    int num;
    num = (int'(v) + ofs) * htp_pkg::PWM_PERIOD;
    if (num <= 0) begin
      return '0;
    end
    num = num / span;
    if (num > htp_pkg::PWM_PERIOD) begin
      num = htp_pkg::PWM_PERIOD;
    end
    return htp_pkg::DUTY_W'(num);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.load = 1'b0;
    // One measurement pair per second
    if (st_r.sec_cnt == SEC_LAST) begin
      st_nxt.sec_cnt = '0;
      st_nxt.tick = 1'b1;
      st_nxt.load = 1'b1;
      // Linear maps, no 0..100 percent clamp
      st_nxt.hum_duty = to_duty(i_HUM_CENTI, htp_pkg::HUM_OFS_CENTI, htp_pkg::HUM_SPAN_CENTI);
      st_nxt.temp_duty = to_duty(i_TEMP_CENTI, htp_pkg::TEMP_OFS_CENTI,
        htp_pkg::TEMP_SPAN_CENTI);
    end else begin
      st_nxt.sec_cnt = st_r.sec_cnt + 1'b1;
    end
    // Pin routing by swap input; relies on it being held firm
    st_nxt.first = i_CHANNEL_SWAP ? hum_pwm : temp_pwm;
    st_nxt.second = i_CHANNEL_SWAP ? temp_pwm : hum_pwm;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  htp_pwm_chan u_hum (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RESETN),
    .i_load(st_r.load),
    .i_duty(st_r.hum_duty),
    .o_pwm(hum_pwm)
  );

  htp_pwm_chan u_temp (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RESETN),
    .i_load(st_r.load),
    .i_duty(st_r.temp_duty),
    .o_pwm(temp_pwm)
  );

  assign o_SAMPLE_TICK = st_r.tick;
  assign o_FIRST_DUTY = st_r.first;
  assign o_SECOND_DUTY = st_r.second;

  AST_ONCE_PER_SEC: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (st_r.sec_cnt == SEC_LAST) |=> (o_SAMPLE_TICK && st_r.load && st_r.sec_cnt == '0))
    else $error("Sample tick missing after one second");
  AST_SWAP_ROUTE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    i_CHANNEL_SWAP |=> (o_FIRST_DUTY == $past(hum_pwm) && o_SECOND_DUTY == $past(temp_pwm)))
    else $error("Pin routing wrong for swap high");
  AST_HUM_MAP: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (st_r.sec_cnt == SEC_LAST && int'(i_HUM_CENTI) >= -600 && int'(i_HUM_CENTI) <= 11900)
    |=> (int'(st_r.hum_duty) * 12500 <= (int'($past(i_HUM_CENTI)) + 600) * 1000
      && (int'($past(i_HUM_CENTI)) + 600) * 1000 < (int'(st_r.hum_duty) + 1) * 12500))
    else $error("Humidity duty off the linear map");
  AST_TEMP_MAP: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (st_r.sec_cnt == SEC_LAST && int'(i_TEMP_CENTI) >= -4685 && int'(i_TEMP_CENTI) <= 12887)
    |=> (int'(st_r.temp_duty) * 17572 <= (int'($past(i_TEMP_CENTI)) + 4685) * 1000
      && (int'($past(i_TEMP_CENTI)) + 4685) * 1000 < (int'(st_r.temp_duty) + 1) * 17572))
    else $error("Temperature duty off the linear map");
  AST_NO_HUM_CLAMP: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    (st_r.sec_cnt == SEC_LAST && int'(i_HUM_CENTI) >= 10100) |=> (st_r.hum_duty > 11'h350))
    else $error("Humidity above 100 percent was clamped");
  AST_SWAP_ROUTE_LOW: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !i_CHANNEL_SWAP |=> (o_FIRST_DUTY == $past(temp_pwm) && o_SECOND_DUTY == $past(hum_pwm)))
    else $error("Pin routing wrong for swap low");
  // Tick is a single-cycle strobe, so the far side never double-counts a sample
  AST_TICK_ONE_CYCLE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    o_SAMPLE_TICK |=> !o_SAMPLE_TICK)
    else $error("Sample tick longer than one cycle");
  AST_SEC_RANGE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    st_r.sec_cnt <= SEC_LAST)
    else $error("Second counter ran past its end");
  // Duty saturates at the waveform limit only
  AST_DUTY_RANGE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    st_r.hum_duty <= 11'h3e8 && st_r.temp_duty <= 11'h3e8)
    else $error("Duty above full scale");
  // Held duties change only with a fresh sample
  AST_DUTY_HELD: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !st_r.load |-> $stable(st_r.hum_duty) && $stable(st_r.temp_duty))
    else $error("Duty changed without a sample");
  COV_SWAP_LOW_LOAD: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    !i_CHANNEL_SWAP && st_r.load);
  COV_SWAP_HIGH_LOAD: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    i_CHANNEL_SWAP && st_r.load);
  COV_HUM_OVER_FULL: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    st_r.load && st_r.hum_duty > 11'h350);
  COV_FULL_DUTY: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
    st_r.hum_duty == 11'h3e8);
endmodule

// [htp_pwm_out_test.sv]
// Purpose: Self-checking bench for the duty-cycle output block
// Assumes: Sample interval shortened to 3000 cycles
// Notes: Expected duties are queued by the driver, popped by the watcher
`timescale 1ns/1ps
module htp_pwm_out_test;
  localparam int SEC = 3000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic swap = 1'b1;
  logic signed [15:0] hum = '0;
  logic signed [15:0] temp = '0;
  logic tick, first, second, v1, v2;
  logic [10:0] m1, m2;
  logic [10:0] q1[$];
  logic [10:0] q2[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int last = -1;
  logic [31:0] seed = 32'h826f0dda;
  always #12.5 clk = ~clk;
  htp_pwm_out #(.SEC_CYCLES(SEC)) i_htp_pwm_out (.I_SYS_CLK(clk), .I_RESETN(resetn),
    .i_CHANNEL_SWAP(swap), .i_HUM_CENTI(hum), .i_TEMP_CENTI(temp),
    .o_SAMPLE_TICK(tick), .o_FIRST_DUTY(first), .o_SECOND_DUTY(second));
  htp_duty_meter i_htp_duty_meter_1 (.i_clk(clk), .i_rst_n(resetn), .i_pwm(first),
    .o_high(m1), .o_valid(v1));
  htp_duty_meter i_htp_duty_meter_2 (.i_clk(clk), .i_rst_n(resetn), .i_pwm(second),
    .o_high(m2), .o_valid(v2));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic bad(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_duty(input logic [10:0] g, input logic [10:0] e);
    checks++;
    if (g !== e) bad($sformatf("duty %0d expected %0d", g, e));
  endtask
  task automatic chk_tick(input int d);
    checks++;
    if (d != SEC) bad($sformatf("tick spacing %0d", d));
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    while (tick !== 1'b1 && n < SEC + 10) begin
      @(posedge clk);
      n++;
    end
    if (n >= SEC + 10) begin
      bad("no sample tick");
      test_done();
    end
  endtask
  task automatic run(input int h, input int t, input logic s);
    int n;
    logic [10:0] dh, dt;
    wait_tick();
    hum <= 16'(h);
    temp <= 16'(t);
    swap <= s;
    @(posedge clk);
    wait_tick();
    repeat (1100) @(posedge clk);
    dh = 11'(((h + htp_pkg::HUM_OFS_CENTI) * 1000) / htp_pkg::HUM_SPAN_CENTI);
    dt = 11'(((t + htp_pkg::TEMP_OFS_CENTI) * 1000) / htp_pkg::TEMP_SPAN_CENTI);
    q1.push_back(s ? dh : dt);
    q2.push_back(s ? dt : dh);
    n = 0;
    while ((q1.size() > 0 || q2.size() > 0) && n < 1200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1200) bad("no duty readback");
    $display("test hum %0d temp %0d swap %0b done", h, t, s);
  endtask
  // Watcher: pulse readback against the oldest note, tick spacing
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (tick === 1'b1) begin
      if (last >= 0) chk_tick(cyc - last);
      last = cyc;
    end
    if (v1 === 1'b1 && q1.size() > 0) chk_duty(m1, q1.pop_front());
    if (v2 === 1'b1 && q2.size() > 0) chk_duty(m2, q2.pop_front());
  end
  initial begin
    int hs[3] = '{5700, 10500, -300};
    int ts[3] = '{2500, -4000, 12000};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Over 100 and under 0 percent pass unclamped
    for (int i = 0; i < 3; i++) run(hs[i], ts[i], i[0] == 1'b0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      run(int'(seed % 12000) - 500, int'((seed >> 8) % 17000) - 4600, seed[3]);
    end
    test_done();
  end
endmodule
